/* hdl/oag_cfg.svh */
// constants for operand address generation
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
`define OAG_RST_ADDR 20'h00000
`define OAG_LOW_PAGE 4'h0
`define OAG_INC_BYTE 20'h00001
`define OAG_INC_WORD 20'h00002
`define OAG_INC_AWORD 20'h00004
`define OAG_IMM_PC_STEP 20'h00002
`define OAG_PAIR_STEP 20'h00002
`define OAG_AL_BW_AWORD 2'h1
`define OAG_AL_BW_BYTE 2'h3
`define OAG_BYTE_MASK 20'h000ff
`define OAG_LEN_BASE 3'h1
`endif

/* hdl/oag_pkg.sv */
// types for operand address generation
package oag_pkg;
  typedef enum logic [2:0] {
    MODE_INDEXED,
    MODE_SYMBOLIC,
    MODE_ABSOLUTE,
    MODE_INDIRECT,
    MODE_AUTOINC,
    MODE_IMMEDIATE
  } mode_e;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_AWORD
  } size_e;

  typedef struct packed {
    mode_e mode;
    logic is_dst;
    logic ext;
    logic al;
    logic bw;
    logic [3:0] ext_nib;
    logic [15:0] idx;
    logic [19:0] idx_addr;
    logic [3:0] rnum;
    logic [19:0] rval;
    logic cg_hit;
    logic [19:0] cg_val;
    logic oth_words;
  } req_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [19:0] addr_hi;
    logic [19:0] imm;
    logic is_imm;
    logic is_mem;
    logic pair;
    logic reg_we;
    logic [19:0] reg_val;
    logic pc_we;
    logic [19:0] pc_next;
    logic [2:0] len;
    logic err;
  } res_s;
endpackage

/* hdl/operand_address_generator.sv */
// operand address and constant generation for one operand
`timescale 1ns/10ps
`include "oag_cfg.svh"
module operand_address_generator (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_req,
  input wire oag_pkg::req_s i_op,
  output logic o_valid,
  output oag_pkg::res_s o_res
);

  // ==========================================
  // size and increment decode
  function automatic oag_pkg::size_e size_of(input logic ext, input logic al,
                                             input logic bw);
    if (ext && ({al, bw} == `OAG_AL_BW_AWORD)) begin
      return oag_pkg::SZ_AWORD;
    end else if (bw) begin
      return oag_pkg::SZ_BYTE;
    end else begin
      return oag_pkg::SZ_WORD;
    end
  endfunction

  function automatic logic [19:0] step_of(input oag_pkg::size_e sz);
    unique case (sz)
      oag_pkg::SZ_BYTE: return `OAG_INC_BYTE;
      oag_pkg::SZ_WORD: return `OAG_INC_WORD;
      oag_pkg::SZ_AWORD: return `OAG_INC_AWORD;
      default: return `OAG_INC_WORD;
    endcase
  endfunction

  // ==========================================
  // state
  logic vld_q;
  oag_pkg::res_s res_q;
  oag_pkg::res_s res_d;
  logic fwd_vld_q;
  logic fwd_vld_d;
  logic [3:0] fwd_num_q;
  logic [19:0] fwd_val_q;

  wire go = i_ce & i_req;
  wire oag_pkg::mode_e mode = i_op.mode;
  wire oag_pkg::size_e sz = size_of(i_op.ext, i_op.al, i_op.bw);
  wire is_rel = (mode == oag_pkg::MODE_SYMBOLIC) || (mode == oag_pkg::MODE_INDEXED);
  wire is_abs = (mode == oag_pkg::MODE_ABSOLUTE);
  wire is_ind = (mode == oag_pkg::MODE_INDIRECT);
  wire is_inc = (mode == oag_pkg::MODE_AUTOINC);
  wire is_imm = (mode == oag_pkg::MODE_IMMEDIATE);

  // ==========================================
  // base selection
  // forward incremented source register
  wire use_fwd = i_op.is_dst & fwd_vld_q & (i_op.rnum == fwd_num_q);
  wire [19:0] reg_eff = use_fwd ? fwd_val_q : i_op.rval;
  // pc base is index word address
  wire [19:0] base = (mode == oag_pkg::MODE_SYMBOLIC) ? i_op.idx_addr : reg_eff;
  wire low_base = (base[19:16] == `OAG_LOW_PAGE);

  // ==========================================
  // relative address
  // index sign-extended, or topped by the extension nibble when extended
  wire [19:0] full_idx = i_op.ext ? {i_op.ext_nib, i_op.idx} : {{4{i_op.idx[15]}}, i_op.idx};
  // full 20-bit sum keeps pc top
  wire [19:0] rel_sum = base + full_idx;
  wire [19:0] rel_addr = (!i_op.ext && low_base) ? {`OAG_LOW_PAGE, rel_sum[15:0]} : rel_sum;

  // ==========================================
  // absolute and immediate values
  // plain absolute in low page
  wire [19:0] abs_addr = i_op.ext ? {i_op.ext_nib, i_op.idx} : {`OAG_LOW_PAGE, i_op.idx};
  wire [19:0] imm_word = (sz == oag_pkg::SZ_BYTE) ? (abs_addr & `OAG_BYTE_MASK) : abs_addr;
  wire [19:0] imm_val = i_op.cg_hit ? i_op.cg_val : imm_word;

  // ==========================================
  // register updates
  // size-dependent increment
  wire [19:0] inc_val = reg_eff + step_of(sz);
  // pc steps by two after constant
  wire [19:0] pc_after = i_op.idx_addr + `OAG_IMM_PC_STEP;

  // ==========================================
  // length
  // constant generator omits the word
  wire op_word = is_rel | is_abs | (is_imm & ~i_op.cg_hit);
  wire [2:0] len = `OAG_LEN_BASE + {2'h0, i_op.ext} + {2'h0, op_word} + {2'h0, i_op.oth_words};

  // ==========================================
  // operand result
  // indirect refused for destination
  wire bad_dst = i_op.is_dst & (is_ind | is_inc | is_imm);
  wire mem_op = ~is_imm & ~bad_dst;
  wire [19:0] op_addr = is_rel ? rel_addr : (is_abs ? abs_addr : reg_eff);

  always_comb begin
    res_d = '0;
    res_d.err = bad_dst;
    res_d.len = len;
    res_d.is_mem = mem_op;
    res_d.is_imm = is_imm & ~bad_dst;
    res_d.imm = (is_imm && !bad_dst) ? imm_val : `OAG_RST_ADDR;
    res_d.addr = mem_op ? op_addr : `OAG_RST_ADDR;
    // second word of a 20-bit operand
    res_d.pair = mem_op & (sz == oag_pkg::SZ_AWORD);
    res_d.addr_hi = res_d.pair ? op_addr + `OAG_PAIR_STEP : `OAG_RST_ADDR;
    res_d.reg_we = is_inc & ~bad_dst;
    res_d.reg_val = res_d.reg_we ? inc_val : `OAG_RST_ADDR;
    res_d.pc_we = is_imm & ~bad_dst & ~i_op.cg_hit;
    res_d.pc_next = res_d.pc_we ? pc_after : `OAG_RST_ADDR;
  end

  always_comb begin
    fwd_vld_d = fwd_vld_q;
    if (i_op.is_dst) begin
      fwd_vld_d = 1'b0;
    end else begin
      fwd_vld_d = is_inc;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      vld_q <= 1'b0;
      res_q <= '0;
      fwd_vld_q <= 1'b0;
      fwd_num_q <= 4'h0;
      fwd_val_q <= `OAG_RST_ADDR;
    end else if (i_ce) begin
      vld_q <= i_req;
      if (i_req) begin
        res_q <= res_d;
        fwd_vld_q <= fwd_vld_d;
        fwd_num_q <= i_op.rnum;
        fwd_val_q <= inc_val;
      end
    end
  end

  assign o_valid = vld_q & i_ce;
  assign o_res = res_q;

  // ==========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_rel_upper: assert property (go && !i_op.ext && mode == oag_pkg::MODE_SYMBOLIC
    && i_op.idx_addr[19:16] != 4'h0 && !bad_dst |=> res_q.addr ==
    $past(i_op.idx_addr) + {{4{$past(i_op.idx[15])}}, $past(i_op.idx)})
    else $error("relative sum above low page wrong");

  chk_low_clear: assert property (go && !i_op.ext && is_rel && low_base
    |=> res_q.addr[19:16] == 4'h0)
    else $error("low page relative address left page");

  chk_ext_rel: assert property (go && i_op.ext && mode == oag_pkg::MODE_SYMBOLIC
    |=> res_q.addr == $past(i_op.idx_addr) + {$past(i_op.ext_nib), $past(i_op.idx)})
    else $error("extended relative address wrong");

  chk_abs_low: assert property (go && !i_op.ext && is_abs
    |=> res_q.addr == {4'h0, $past(i_op.idx)})
    else $error("absolute address not the index word");

  chk_abs_ext: assert property (go && i_op.ext && is_abs
    |=> res_q.addr == {$past(i_op.ext_nib), $past(i_op.idx)})
    else $error("extended absolute address wrong");

  chk_inc_step: assert property (go && is_inc && !i_op.is_dst && !use_fwd
    |=> res_q.reg_we && res_q.reg_val - res_q.addr == step_of($past(sz)))
    else $error("autoincrement step wrong");

  chk_fwd_base: assert property (go && i_op.is_dst && mode == oag_pkg::MODE_INDEXED
    && i_op.ext && res_q.reg_we && i_op.rnum == fwd_num_q
    |=> res_q.addr == $past(res_q.reg_val) + {$past(i_op.ext_nib), $past(i_op.idx)})
    else $error("destination did not see incremented register");

  chk_imm_pc: assert property (go && is_imm && !i_op.cg_hit && !i_op.is_dst
    |=> res_q.pc_we && res_q.pc_next == $past(i_op.idx_addr) + 20'h00002)
    else $error("immediate pc advance wrong");

  chk_dst_err: assert property (go && i_op.is_dst && (is_ind || is_inc)
    |=> res_q.err && !res_q.is_mem && !res_q.reg_we)
    else $error("destination indirect mode accepted");

  chk_len: assert property (go && op_word && !i_op.cg_hit
    |=> res_q.len >= ($past(i_op.ext) ? 3'h3 : 3'h2)
    && res_q.len <= ($past(i_op.ext) ? 3'h4 : 3'h3))
    else $error("instruction length out of range");

  chk_pair: assert property (go && mem_op && sz == oag_pkg::SZ_AWORD
    |=> res_q.pair && res_q.addr_hi == res_q.addr + 20'h00002)
    else $error("address-word pair address wrong");

  chk_ind_addr: assert property (go && is_ind && !i_op.is_dst
    |=> res_q.is_mem && !res_q.reg_we && res_q.addr == $past(i_op.rval))
    else $error("indirect address not the register");

  chk_inc_addr: assert property (go && is_inc && !i_op.is_dst
    |=> res_q.is_mem && !res_q.err && res_q.addr == $past(i_op.rval))
    else $error("autoincrement address not the register");

  chk_dst_ok: assert property (go && i_op.is_dst && (is_rel || is_abs)
    |=> res_q.is_mem && !res_q.err)
    else $error("destination relative or absolute refused");

  chk_imm_word: assert property (go && is_imm && !i_op.ext && !i_op.bw && !i_op.cg_hit
    && !i_op.is_dst |=> res_q.is_imm && res_q.imm == {4'h0, $past(i_op.idx)})
    else $error("word constant wrong");

  chk_imm_byte: assert property (go && is_imm && !i_op.ext && i_op.bw && !i_op.cg_hit
    && !i_op.is_dst |=> res_q.imm == {12'h000, $past(i_op.idx[7:0])})
    else $error("byte constant not masked");

  chk_imm_ext: assert property (go && is_imm && i_op.ext && sz == oag_pkg::SZ_AWORD
    && !i_op.cg_hit && !i_op.is_dst |=> res_q.imm == {$past(i_op.ext_nib), $past(i_op.idx)})
    else $error("extended constant wrong");

  chk_cg_const: assert property (go && is_imm && i_op.cg_hit && !i_op.is_dst
    |=> !res_q.pc_we && res_q.imm == $past(i_op.cg_val)
    && res_q.len == 3'h1 + {2'h0, $past(i_op.ext)} + {2'h0, $past(i_op.oth_words)})
    else $error("generator constant handled wrong");

  chk_imm_nomem: assert property (go && is_imm && !i_op.is_dst
    |=> res_q.is_imm && !res_q.is_mem && res_q.addr == 20'h00000)
    else $error("immediate shown as memory operand");

  chk_imm_dst: assert property (go && is_imm && i_op.is_dst
    |=> res_q.err && !res_q.is_imm && !res_q.pc_we)
    else $error("destination immediate accepted");

  chk_err_noaddr: assert property (go && bad_dst
    |=> res_q.addr == 20'h00000 && !res_q.pair)
    else $error("refused operand shows an address");

  chk_pair_only: assert property (go && mem_op && sz != oag_pkg::SZ_AWORD
    |=> !res_q.pair && res_q.addr_hi == 20'h00000)
    else $error("pair without address-word size");

  chk_valid_pulse: assert property (i_ce && !i_req |=> !vld_q)
    else $error("valid without request");

endmodule

/* testbench/oag_mem_model.sv */
// register file and memory read model for the operand generator
`timescale 1ns/10ps
module oag_mem_model (
  input wire logic [3:0] i_rnum,
  input wire logic [19:0] i_addr,
  output logic [19:0] o_rval,
  output logic [15:0] o_word
);
  // ======
  // low registers point into the lower page
  assign o_rval = {i_rnum[3] ? i_rnum : 4'h0, i_rnum ^ 4'hb, 12'h79c};
  assign o_word = i_addr[16:1] ^ 16'h8f3b;
endmodule

/* testbench/operand_address_generator_bench.sv */
// self-checking bench for operand address generation
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %h seen %h", n, e, s); end end
module operand_address_generator_bench;
  logic i_clk, i_sys_rst, i_ce, i_req, o_valid, fwd_ok;
  oag_pkg::req_s i_op;
  oag_pkg::res_s o_res;
  logic [3:0] sel_r, fwd_r;
  logic [19:0] sel_a, p_rval, fwd_v;
  logic [15:0] p_word;
  logic [31:0] rs;
  int mismatches = 0;
  int compares = 0;
  oag_pkg::req_s tbl[$];

  operand_address_generator DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_req(i_req), .i_op(i_op), .o_valid(o_valid), .o_res(o_res));
  oag_mem_model u_mem (.i_rnum(sel_r), .i_addr(sel_a), .o_rval(p_rval), .o_word(p_word));

  always #5 i_clk = ~i_clk;

  // ======
  // helpers and expected results
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // mode code, {dst, ext, al, bw}, nibble, index word, its address
  function automatic oag_pkg::req_s mk(input logic [2:0] m, input logic [3:0] f,
      input logic [3:0] nb, input logic [15:0] ix, input logic [19:0] ia);
    oag_pkg::req_s q;
    q = '0;
    q.mode = oag_pkg::mode_e'(m);
    {q.is_dst, q.ext, q.al, q.bw, q.ext_nib, q.idx, q.idx_addr} = {f, nb, ix, ia};
    q.rnum = 4'h5;
    q.rval = 20'h3579c;
    return q;
  endfunction

  function automatic oag_pkg::res_s expf(input oag_pkg::req_s q);
    oag_pkg::res_s r;
    logic [19:0] b;
    logic [19:0] fl;
    logic aw;
    logic fw;
    r = '0;
    r.err = q.is_dst && q.mode >= oag_pkg::MODE_INDIRECT;
    if (r.err)
      return r;
    fl = {q.ext_nib, q.idx};
    aw = q.ext && {q.al, q.bw} == 2'h1;
    b = (fwd_ok && q.is_dst && q.rnum == fwd_r) ? fwd_v : q.rval;
    if (q.mode == oag_pkg::MODE_SYMBOLIC)
      b = q.idx_addr;
    fw = q.mode <= oag_pkg::MODE_ABSOLUTE;
    r.is_mem = q.mode <= oag_pkg::MODE_AUTOINC;
    if (q.mode == oag_pkg::MODE_ABSOLUTE)
      r.addr = q.ext ? fl : {4'h0, q.idx};
    else if (fw)
      r.addr = b + (q.ext ? fl : {{4{q.idx[15]}}, q.idx});
    else if (r.is_mem)
      r.addr = q.rval;
    if (fw && !q.ext && b[19:16] == 4'h0)
      r.addr[19:16] = 4'h0;
    r.reg_we = q.mode == oag_pkg::MODE_AUTOINC;
    r.reg_val = q.rval + (aw ? 20'h4 : q.bw ? 20'h1 : 20'h2);
    r.is_imm = q.mode == oag_pkg::MODE_IMMEDIATE;
    r.imm = q.cg_hit ? q.cg_val : (q.ext ? fl : {4'h0, q.idx});
    if (q.bw && !aw)
      r.imm = r.imm & 20'hff;
    r.pc_we = r.is_imm && !q.cg_hit;
    r.pc_next = q.idx_addr + 20'h2;
    r.pair = r.is_mem && aw;
    r.addr_hi = r.addr + 20'h2;
    r.len = 3'h1 + 3'(q.ext) + 3'(fw | r.pc_we) + 3'(q.oth_words);
    return r;
  endfunction

  // ======
  // one request, answer checked one cycle later, or two when ce drops
  task automatic run(input oag_pkg::req_s q);
    oag_pkg::res_s e;
    e = expf(q);
    @(posedge i_clk);
    i_req <= 1'b1;
    i_op <= q;
    @(posedge i_clk);
    rs = lfsr(rs);
    i_req <= 1'b0;
    i_ce <= rs[0] | rs[1];
    @(negedge i_clk);
    if (!i_ce) begin
      `CHK("ce hold", 1'b0, o_valid)
      @(posedge i_clk) i_ce <= 1'b1;
      @(negedge i_clk);
    end
    `CHK("valid", 1'b1, o_valid)
    `CHK("err", e.err, o_res.err)
    `CHK("mem", e.is_mem, o_res.is_mem)
    `CHK("wb", e.reg_we, o_res.reg_we)
    if (e.is_mem) `CHK("addr", e.addr, o_res.addr)
    if (e.is_mem) `CHK("pair", e.pair, o_res.pair)
    if (e.pair) `CHK("addr hi", e.addr_hi, o_res.addr_hi)
    if (e.reg_we) `CHK("wb val", e.reg_val, o_res.reg_val)
    if (!e.err) `CHK("pc we", e.pc_we, o_res.pc_we)
    if (e.pc_we) `CHK("pc", e.pc_next, o_res.pc_next)
    if (e.is_imm) `CHK("imm", e.imm, o_res.imm)
    `CHK("is imm", e.is_imm, o_res.is_imm)
    if (!e.err) `CHK("len", e.len, o_res.len)
    @(negedge i_clk);
    `CHK("pulse", 1'b0, o_valid)
    fwd_ok = !q.is_dst && e.reg_we;
    fwd_r = q.rnum;
    fwd_v = e.reg_val;
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    print_verdict();
  end

  // ======
  // main sequence
  initial begin
    oag_pkg::req_s q;
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_req = 1'b0;
    i_op = '0;
    sel_r = 4'h0;
    sel_a = 20'h0;
    rs = 32'h4b45;
    fwd_ok = 1'b0;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    `CHK("rst valid", 1'b0, o_valid)
    `CHK("rst res", 1'b0, |o_res)
    $display("test reset done");
    tbl.push_back(mk(3'h1, 4'h0, 4'h0, 16'h4766, 20'h2f036));
    tbl.push_back(mk(3'h1, 4'h8, 4'h0, 16'hf740, 20'h01038));
    tbl.push_back(mk(3'h1, 4'h0, 4'h0, 16'h0020, 20'hffff0));
    tbl.push_back(mk(3'h1, 4'h8, 4'h0, 16'h8000, 20'h10004));
    tbl.push_back(mk(3'h1, 4'h4, 4'h1, 16'h4766, 20'h21036));
    tbl.push_back(mk(3'h1, 4'hd, 4'h5, 16'h6740, 20'h21038));
    tbl.push_back(mk(3'h2, 4'h8, 4'h0, 16'h0778, 20'h0));
    tbl.push_back(mk(3'h2, 4'h5, 4'h7, 16'h7778, 20'h0));
    tbl.push_back(mk(3'h3, 4'h0, 4'h0, 16'h0, 20'h0));
    tbl.push_back(mk(3'h3, 4'h8, 4'h0, 16'h0, 20'h0));
    tbl.push_back(mk(3'h4, 4'h1, 4'h0, 16'h0, 20'h0));
    tbl.push_back(mk(3'h0, 4'h8, 4'h0, 16'h0, 20'h0));
    tbl.push_back(mk(3'h4, 4'h5, 4'h0, 16'h0, 20'h0));
    tbl.push_back(mk(3'h0, 4'hc, 4'h0, 16'h0010, 20'h0));
    tbl.push_back(mk(3'h4, 4'h8, 4'h0, 16'h0, 20'h0));
    tbl.push_back(mk(3'h5, 4'h5, 4'h2, 16'h3456, 20'h21036));
    tbl.push_back(mk(3'h5, 4'h7, 4'hf, 16'hff34, 20'h21034));
    tbl.push_back(mk(3'h5, 4'h8, 4'h0, 16'h3456, 20'h21034));
    foreach (tbl[k])
      run(tbl[k]);
    $display("test corner done");
    repeat (300) begin
      rs = lfsr(rs);
      sel_r = rs[15:12];
      sel_a = {rs[31:13], 1'b0};
      #1;
      q = mk(rs[2:0] % 3'h6, rs[6:3], rs[10:7], p_word, sel_a);
      q.rnum = sel_r;
      q.rval = p_rval;
      q.oth_words = rs[11];
      q.cg_hit = rs[16] & rs[17] & !q.bw;
      q.cg_val = {16'h0, rs[21:18]};
      run(q);
    end
    $display("test random done");
    print_verdict();
  end
endmodule
